// >>> mgmt_pkg.sv
// shared constants and field layout of the low-speed management block
package mgmt_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ          = 50;
  localparam int INIT_TIME_MS     = 2000;
  localparam int INIT_CYCLES      = INIT_TIME_MS * CLK_MHZ * 1000;
  localparam int RESET_MIN_NS     = 2000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int LOW_W            = $clog2(RESET_MIN_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // lanes and link
  localparam int         LANES       = 4;
  localparam int         MAP_BYTES   = 8;
  localparam logic [6:0] TARGET_ADDR = 7'h50;

  //////////////////////////////////////////////////////////////////////////////
  // byte offsets in the serial memory map
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_FLAGS   = 8'h01;
  localparam logic [7:0] OFS_LOS     = 8'h02;
  localparam logic [7:0] OFS_CONTROL = 8'h03;
  localparam logic [7:0] OFS_POWER0  = 8'h04;

  //////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam logic [2:0] STATUS_NOT_READY   = 3'h0;
  localparam logic [2:0] STATUS_LOW_POWER   = 3'h1;
  localparam logic [2:0] STATUS_TX_OFF      = 3'h2;
  localparam logic [2:0] FLAGS_RESET_DONE   = 3'h4;
  localparam logic [2:0] CONTROL_TX_DISABLE = 3'h0;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;

endpackage

// >>> sync_bit.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module sync_bit #(
  parameter int width = 1
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             ce,
  input  wire logic [width-1:0] d,
  output logic      [width-1:0] q
);

  logic [width-1:0] stage;

  // stage is read by q alone
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage <= '0;
      q     <= '0;
    end else if (ce) begin
      stage <= d;
      q     <= stage;
    end
  end

endmodule

// >>> twowire_target.sv
// two-wire serial target running on the host serial clock
`timescale 1ns/1ps
module twowire_target (
  input  wire logic        scl,
  input  wire logic        linkRstN,
  input  wire logic        sdaIn,
  input  wire logic        moduleSelectN,
  input  wire logic        imageReqTog,
  input  wire logic [63:0] imageIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             imageAckTog,
  output logic             wrTog,
  output logic [2:0]       wrIndex,
  output logic [7:0]       wrData,
  output logic             clearTog,
  output logic [7:0]       clearByte
);

  typedef enum {T_IDLE, T_ADDR, T_PTR, T_WDATA, T_RDATA} linkState_t;

  linkState_t  state;
  logic        startTog;
  logic        startAck;
  logic        selMeta;
  logic        selected;
  logic        reqMeta;
  logic        reqSync;
  logic [63:0] linkImage;
  logic [3:0]  bitCnt;
  logic [7:0]  shift;
  logic [7:0]  ptr;
  logic [7:0]  txByte;

  function automatic logic [7:0] mapByte(input logic [7:0] idx, input logic [63:0] img);
    mapByte = (idx < 8'(mgmt_pkg::MAP_BYTES)) ? img[idx[2:0]*8 +: 8] : 8'h00;
  endfunction

  wire startSeen = startTog != startAck;
  wire byteDone  = bitCnt == 4'h8;
  wire addrMatch = shift[7:1] == mgmt_pkg::TARGET_ADDR;
  wire txBit     = txByte[3'(4'h7 - bitCnt)];
  wire ackDrive  = byteDone && ((state == T_ADDR && addrMatch && selected)
                   || state == T_PTR || state == T_WDATA);
  wire readDrive = state == T_RDATA && !byteDone && !txBit;

  //////////////////////////////////////////////////////////////////////////////
  // start condition: data falls while the clock is high
  always_ff @(negedge sdaIn or negedge linkRstN) begin
    if (!linkRstN) begin
      startTog <= 1'b0;
    end else if (scl) begin
      startTog <= ~startTog;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sampling edge; the clock stands still between frames, so the image copy
  // and the select level only refresh while the host is clocking
  always_ff @(posedge scl or negedge linkRstN) begin
    if (!linkRstN) begin
      selMeta     <= 1'b0;
      selected    <= 1'b0;
      reqMeta     <= 1'b0;
      reqSync     <= 1'b0;
      imageAckTog <= 1'b0;
      linkImage   <= '0;
    end else begin
      selMeta  <= ~moduleSelectN;
      selected <= selMeta;
      reqMeta  <= imageReqTog;
      reqSync  <= reqMeta;
      if (reqSync != imageAckTog) begin
        linkImage   <= imageIn;
        imageAckTog <= reqSync;
      end
    end
  end

  always_ff @(posedge scl or negedge linkRstN) begin
    if (!linkRstN) begin
      state     <= T_IDLE;
      startAck  <= 1'b0;
      bitCnt    <= 4'h0;
      shift     <= 8'h00;
      ptr       <= 8'h00;
      txByte    <= 8'h00;
      wrTog     <= 1'b0;
      wrIndex   <= 3'h0;
      wrData    <= 8'h00;
      clearTog  <= 1'b0;
      clearByte <= 8'h00;
    end else if (startSeen) begin
      startAck <= startTog;
      state    <= T_ADDR;
      shift    <= {7'h00, sdaIn};
      bitCnt   <= 4'h1;
    end else if (state != T_IDLE && !byteDone) begin
      shift  <= {shift[6:0], sdaIn};
      bitCnt <= bitCnt + 4'h1;
    end else if (state != T_IDLE) begin
      bitCnt <= 4'h0;
      case (state)
        T_ADDR: begin
          if (!(addrMatch && selected)) begin
            state <= T_IDLE;
          end else if (shift[0]) begin
            state  <= T_RDATA;
            txByte <= mapByte(ptr, linkImage);
          end else begin
            state <= T_PTR;
          end
        end
        T_PTR: begin
          ptr   <= shift;
          state <= T_WDATA;
        end
        T_WDATA: begin
          wrIndex <= ptr[2:0];
          wrData  <= shift;
          ptr     <= ptr + 8'h01;
          if (ptr < 8'(mgmt_pkg::MAP_BYTES)) begin
            wrTog <= ~wrTog;
          end
        end
        T_RDATA: begin
          if (ptr == mgmt_pkg::OFS_FLAGS) begin
            clearByte <= txByte;
            clearTog  <= ~clearTog;
          end
          if (!sdaIn) begin
            ptr    <= ptr + 8'h01;
            txByte <= mapByte(ptr + 8'h01, linkImage);
          end else begin
            state <= T_IDLE;
          end
        end
        default: state <= T_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // driving edge; open drain, so only the enable ever changes
  always_ff @(negedge scl or negedge linkRstN) begin
    if (!linkRstN) begin
      sdaOut <= 1'b0;
      sdaOe  <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      sdaOe  <= ackDrive || readDrive;
    end
  end

  AST_ACK_ONLY_SELECTED: assert property (
    @(posedge scl) disable iff (!linkRstN)
    sdaOe && state == T_ADDR |-> selected && addrMatch && byteDone)
    else $error("address acknowledged while not selected");

  AST_READ_BIT: assert property (
    @(posedge scl) disable iff (!linkRstN)
    state == T_RDATA && !byteDone && !$past(startSeen) |-> sdaOe == !txBit)
    else $error("read data bit not presented");

endmodule

// >>> module_low_speed_management.sv
// low-speed management logic of a four-lane pluggable optical module
`timescale 1ns/1ps
module module_low_speed_management #(
  parameter int unsigned initCycles = mgmt_pkg::INIT_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         ce,
  input  wire logic                         scl,
  input  wire logic                         sdaIn,
  output logic                              sdaOut,
  output logic                              sdaOe,
  input  wire logic                         moduleSelectN,
  input  wire logic                         moduleResetN,
  input  wire logic                         lowPowerRequest,
  input  wire logic                         transmitDisable,
  input  wire logic [mgmt_pkg::LANES-1:0]   laneSignalLow,
  input  wire logic [8*mgmt_pkg::LANES-1:0] diagnosticMonitor,
  output logic                              presenceN,
  output logic                              attentionN,
  output logic                              attentionOe,
  output logic                              receiveSignalLoss,
  output logic                              transmitOff,
  output logic                              powerLimit,
  output logic                              dataNotReady
);

  typedef enum {ST_INIT, ST_READY} mgmtState_t;

  localparam int NSYNC = mgmt_pkg::LANES + 6;

  mgmtState_t                       state;
  mgmtState_t                       next_state;
  logic [NSYNC-1:0]                 rawIn;
  logic [NSYNC-1:0]                 syncIn;
  logic                             imageAckTog;
  logic                             wrTog;
  logic                             clearTog;
  logic [2:0]                       wrIndex;
  logic [7:0]                       wrData;
  logic [7:0]                       clearByte;
  logic                             wrSeen;
  logic                             clrSeen;
  logic [mgmt_pkg::LOW_W-1:0]       lowCnt;
  logic [31:0]                      initCnt;
  logic [4:0]                       flags;
  logic [4:0]                       next_flags;
  logic [mgmt_pkg::LANES-1:0]       losPrev;
  logic                             softTx;
  logic                             next_softTx;
  logic [63:0]                      image;
  logic [63:0]                      next_image;
  logic                             reqTog;

  function automatic logic [7:0] placeBit(input logic [2:0] pos, input logic v);
    placeBit = {7'h00, v} << pos;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin and crossing inputs; every one but diagnosticMonitor, wrIndex, wrData and clearByte is two flops deep before use
  assign rawIn = {laneSignalLow, transmitDisable, lowPowerRequest, moduleResetN,
                  imageAckTog, wrTog, clearTog};

  sync_bit #(
    .width (NSYNC)
  ) inSync (
    .clk  (sys_clk),
    .rstN (nrst),
    .ce   (ce),
    .d    (rawIn),
    .q    (syncIn)
  );

  wire [mgmt_pkg::LANES-1:0] losSync = syncIn[NSYNC-1:6];
  wire txPinSync = syncIn[5];
  wire lpSync    = syncIn[4];
  wire resetSync = syncIn[3];
  wire ackSync   = syncIn[2];
  wire wrSync    = syncIn[1];
  wire clrSync   = syncIn[0];

  wire wrEvt  = wrSync ^ wrSeen;
  wire clrEvt = clrSync ^ clrSeen;

  //////////////////////////////////////////////////////////////////////////////
  // serial target on the host clock
  twowire_target link (
    .scl           (scl),
    .linkRstN      (nrst),
    .sdaIn         (sdaIn),
    .moduleSelectN (moduleSelectN),
    .imageReqTog   (reqTog),
    .imageIn       (image),
    .sdaOut        (sdaOut),
    .sdaOe         (sdaOe),
    .imageAckTog   (imageAckTog),
    .wrTog         (wrTog),
    .wrIndex       (wrIndex),
    .wrData        (wrData),
    .clearTog      (clearTog),
    .clearByte     (clearByte)
  );

  //////////////////////////////////////////////////////////////////////////////
  // reset pulse qualification and initialisation
  // short pulses on the reset pin are filtered out once ready; during initialisation they restart the count
  wire fullReset = lowCnt == mgmt_pkg::LOW_W'(mgmt_pkg::RESET_MIN_CYCLES);
  wire initDone  = state == ST_INIT && resetSync && initCnt == 32'(initCycles - 1);

  always_comb begin
    next_state = state;
    if (fullReset) begin
      next_state = ST_INIT;
    end else if (initDone) begin
      next_state = ST_READY;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lowCnt <= '0;
    end else if (ce) begin
      if (resetSync) begin
        lowCnt <= '0;
      end else if (!fullReset) begin
        lowCnt <= lowCnt + mgmt_pkg::LOW_W'(1);
      end
    end
  end

  // the counter holds at zero while the pin stays low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      initCnt <= 32'h0000_0000;
    end else if (ce) begin
      if (state != ST_INIT || !resetSync) begin
        initCnt <= 32'h0000_0000;
      end else if (!initDone) begin
        initCnt <= initCnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_INIT;
    end else if (ce) begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latched flags; a new event wins over a clear in the same cycle
  wire [mgmt_pkg::LANES-1:0] losRise = losSync & ~losPrev;
  wire [4:0] clearMask = clrEvt ? clearByte[4:0] : 5'h00;

  always_comb begin
    if (state == ST_INIT || fullReset) begin
      next_flags = {initDone, 4'h0};
    end else begin
      next_flags = (flags & ~clearMask) | {1'b0, losRise};
    end
  end

  // writes during initialisation are dropped with the defaults
  always_comb begin
    if (state == ST_INIT || fullReset) begin
      next_softTx = mgmt_pkg::CONTROL_RESET[mgmt_pkg::CONTROL_TX_DISABLE];
    end else if (wrEvt && wrIndex == mgmt_pkg::OFS_CONTROL[2:0]) begin
      next_softTx = wrData[mgmt_pkg::CONTROL_TX_DISABLE];
    end else begin
      next_softTx = softTx;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flags   <= 5'h00;
      losPrev <= '0;
      softTx  <= mgmt_pkg::CONTROL_RESET[mgmt_pkg::CONTROL_TX_DISABLE];
      wrSeen  <= 1'b0;
      clrSeen <= 1'b0;
    end else if (ce) begin
      flags   <= next_flags;
      losPrev <= losSync;
      softTx  <= next_softTx;
      wrSeen  <= wrSync;
      clrSeen <= clrSync;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // readable image; republished whenever the link has taken the last one
  // trade-off: a read may see a value a few link clocks old
  wire [7:0] statusByte = placeBit(mgmt_pkg::STATUS_NOT_READY, dataNotReady)
                        | placeBit(mgmt_pkg::STATUS_LOW_POWER, powerLimit)
                        | placeBit(mgmt_pkg::STATUS_TX_OFF, transmitOff);
  wire [7:0] controlByte = placeBit(mgmt_pkg::CONTROL_TX_DISABLE, softTx);

  always_comb begin
    next_image = 64'h0000_0000_0000_0000;
    next_image[8*mgmt_pkg::OFS_STATUS[2:0] +: 8]  = statusByte;
    next_image[8*mgmt_pkg::OFS_FLAGS[2:0] +: 8]   = {3'h0, flags};
    next_image[8*mgmt_pkg::OFS_LOS[2:0] +: 8]     = {4'h0, losSync};
    next_image[8*mgmt_pkg::OFS_CONTROL[2:0] +: 8] = controlByte;
    next_image[8*mgmt_pkg::OFS_POWER0[2:0] +: 32] = diagnosticMonitor;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      image  <= 64'h0000_0000_0000_0000;
      reqTog <= 1'b0;
    end else if (ce && ackSync == reqTog) begin
      image  <= next_image;
      reqTog <= ~reqTog;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      presenceN         <= 1'b0;
      attentionN        <= 1'b0;
      attentionOe       <= 1'b0;
      receiveSignalLoss <= 1'b0;
      transmitOff       <= 1'b0;
      powerLimit        <= 1'b0;
      dataNotReady      <= 1'b1;
    end else if (ce) begin
      presenceN         <= 1'b0;
      attentionN        <= 1'b0;
      attentionOe       <= |next_flags;
      receiveSignalLoss <= |losSync;
      transmitOff       <= txPinSync || softTx;
      powerLimit        <= lpSync;
      dataNotReady      <= next_state != ST_READY;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence readyEntered;
    state == ST_INIT && ce ##1 state == ST_READY;
  endsequence

  sequence longLowSeen;
    ce && !resetSync && lowCnt == mgmt_pkg::LOW_W'(mgmt_pkg::RESET_MIN_CYCLES - 1);
  endsequence

  AST_DONE_INTERRUPT: assert property (
    readyEntered |-> attentionOe && !dataNotReady && flags[mgmt_pkg::FLAGS_RESET_DONE])
    else $error("reset completion not signalled");

  AST_POWERUP_DONE: assert property (
    ce && initDone |=> state == ST_READY && attentionOe)
    else $error("initialisation end without interrupt");

  AST_FULL_RESET: assert property (
    longLowSeen |=> fullReset ##1 (state == ST_INIT && !softTx && dataNotReady))
    else $error("long reset pulse did not restore defaults");

  AST_LOW_POWER: assert property (
    ce |=> powerLimit == $past(lpSync))
    else $error("power limit does not follow request");

  AST_PRESENCE: assert property (
    presenceN == 1'b0)
    else $error("presence line not grounded");

  AST_OPEN_DRAIN: assert property (
    attentionN == 1'b0)
    else $error("interrupt line driven high");

  AST_TX_OFF: assert property (
    ce && (txPinSync || softTx) |=> transmitOff)
    else $error("transmitter left on while disabled");

  AST_LOS_ALARM: assert property (
    ce |=> receiveSignalLoss == $past(|losSync))
    else $error("loss alarm missing for weak lane");

  AST_RELEASE: assert property (
    ce && state == ST_READY && !fullReset && clrEvt && losRise == '0
    && (flags & ~clearByte[4:0]) == 5'h00 |=> !attentionOe)
    else $error("interrupt held after causes were read");

  AST_SET_WINS: assert property (
    ce && state == ST_READY && !fullReset && |losRise |=> |flags[3:0] && attentionOe)
    else $error("flag lost against clear");

  sequence controlWritten;
    ce && state == ST_READY && !fullReset && wrEvt
    && wrIndex == mgmt_pkg::OFS_CONTROL[2:0];
  endsequence

  AST_SOFT_WRITE: assert property (
    controlWritten |=> softTx == $past(wrData[mgmt_pkg::CONTROL_TX_DISABLE]))
    else $error("control write not applied");

  AST_TX_ON: assert property (
    ce && !txPinSync && !softTx |=> !transmitOff)
    else $error("transmitter off with no disable request");

  AST_SHORT_PULSE: assert property (
    ce && state == ST_READY && !fullReset |=> state == ST_READY)
    else $error("ready left without a full reset");

  AST_NOT_READY: assert property (
    ce && state == ST_INIT && !initDone |=> dataNotReady && flags == 5'h00)
    else $error("ready shown during initialisation");

  AST_OE_FLAGS: assert property (
    ce |=> attentionOe == |flags)
    else $error("interrupt does not match pending flags");

  // frozen cycles must not change power limit, transmit off or the interrupt enable
  AST_FROZEN: assert property (
    !ce |=> $stable(powerLimit) && $stable(transmitOff) && $stable(attentionOe))
    else $error("outputs moved while clock enable low");

endmodule

// >>> host_model.sv
// two-wire host controller model for the management block
`timescale 1ns/1ps
module host_model (
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sdaLine
);
  // clock stands high between frames; 48 ns per bit
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic bitx(input logic b, output logic s);
    #12 sdaLow = ~b;
    #12 scl = 1'b1;
    #12 s = sdaLine;
    #12 scl = 1'b0;
  endtask
  // also serves as repeated start
  task automatic start();
    #12 sdaLow = 1'b0;
    #12 scl = 1'b1;
    #12 sdaLow = 1'b1;
    #12 scl = 1'b0;
  endtask
  task automatic stop();
    #12 sdaLow = 1'b1;
    #12 scl = 1'b1;
    #12 sdaLow = 1'b0;
  endtask
  // rel high leaves the ack slot to the target or ends a read
  task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], s);
      rx[i] = s;
    end
    bitx(rel, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] j;
    logic       a0, a1, a2;
    start();
    xfer({mgmt_pkg::TARGET_ADDR, 1'b0}, 1'b1, j, a0);
    xfer(ptr, 1'b1, j, a1);
    xfer(d, 1'b1, j, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] j;
    logic       a0, a1, a2, n;
    start();
    xfer({mgmt_pkg::TARGET_ADDR, 1'b0}, 1'b1, j, a0);
    xfer(ptr, 1'b1, j, a1);
    start();
    xfer({mgmt_pkg::TARGET_ADDR, 1'b1}, 1'b1, j, a2);
    xfer(8'hff, 1'b1, d, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// >>> tb.sv
// self-checking bench of the low-speed management block
`timescale 1ns/1ps
module tb;
  localparam int INIT = 40;
  logic        sys_clk, nrst, ce, scl, sdaLow, sdaOut, sdaOe, moduleSelectN;
  logic        moduleResetN, lowPowerRequest, transmitDisable, presenceN, attentionN;
  logic        attentionOe, receiveSignalLoss, transmitOff, powerLimit, dataNotReady;
  logic        ok, ctl;
  logic [3:0]  laneSignalLow, flagsExp, prevLanes;
  logic [7:0]  d;
  logic [31:0] diagnosticMonitor, seed, r;
  int          n_errors, cmp_count;
  // pull-up on the shared data line
  wire         sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));

  module_low_speed_management #(.initCycles(INIT)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .moduleSelectN(moduleSelectN), .moduleResetN(moduleResetN),
    .lowPowerRequest(lowPowerRequest), .transmitDisable(transmitDisable),
    .laneSignalLow(laneSignalLow), .diagnosticMonitor(diagnosticMonitor),
    .presenceN(presenceN), .attentionN(attentionN), .attentionOe(attentionOe),
    .receiveSignalLoss(receiveSignalLoss), .transmitOff(transmitOff),
    .powerLimit(powerLimit), .dataNotReady(dataNotReady));
  host_model host_u (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic logic [7:0] expStatus(input logic nr, input logic lp, input logic tx);
    return {5'h00, tx, lp, nr};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // status is not trusted until the module reports ready
  task automatic waitReady();
    for (int i = 0; i < 1000 && dataNotReady !== 1'b0; i++) @(negedge sys_clk);
    chk(dataNotReady, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial begin
    #1ms;
    n_errors++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    moduleSelectN = 1'b0; // one select line per module
    moduleResetN = 1'b1;
    {lowPowerRequest, transmitDisable, laneSignalLow, diagnosticMonitor} = '0;
    seed = 32'd57476;
    flagsExp = 4'h0;
    prevLanes = 4'h0;
    idle(20);
    chk({presenceN, attentionN, attentionOe, dataNotReady}, 32'h1);
    nrst = 1'b1;
    waitReady();
    chk(attentionOe, 32'h1);
    chk({presenceN, attentionN, sdaOut}, 32'h0);
    host_u.rd(mgmt_pkg::OFS_STATUS, d, ok);
    chk({ok, d}, {1'b1, expStatus(1'b0, 1'b0, 1'b0)});
    host_u.rd(mgmt_pkg::OFS_FLAGS, d, ok);
    chk({ok, d}, 32'h110);
    idle(10);
    chk(attentionOe, 32'h0);
    // unselected module must leave the bus alone
    moduleSelectN = 1'b1;
    host_u.rd(mgmt_pkg::OFS_STATUS, d, ok);
    chk({ok, d}, 32'h0ff);
    idle(1);
    moduleSelectN = 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(negedge sys_clk);
      seed = xs(seed);
      r = seed;
      seed = xs(seed);
      diagnosticMonitor = seed;
      laneSignalLow = (k == 0) ? 4'hf : r[3:0];
      transmitDisable = r[4];
      lowPowerRequest = r[5];
      ctl = r[6];
      flagsExp = flagsExp | (laneSignalLow & ~prevLanes);
      prevLanes = laneSignalLow;
      host_u.wr(mgmt_pkg::OFS_CONTROL, {7'h00, ctl}, ok);
      chk(ok, 32'h1);
      idle(10);
      chk({transmitOff, powerLimit}, {transmitDisable | ctl, lowPowerRequest});
      chk(receiveSignalLoss, |laneSignalLow);
      chk(attentionOe, |flagsExp);
      host_u.rd(mgmt_pkg::OFS_CONTROL, d, ok);
      chk(d, {7'h00, ctl});
      host_u.rd(mgmt_pkg::OFS_LOS, d, ok);
      chk(d, {4'h0, laneSignalLow});
      host_u.rd(mgmt_pkg::OFS_STATUS, d, ok);
      chk(d, expStatus(1'b0, lowPowerRequest, transmitDisable | ctl));
      host_u.rd(mgmt_pkg::OFS_POWER0 + {6'h00, r[8:7]}, d, ok);
      chk(d, diagnosticMonitor[8*r[8:7] +: 8]);
      host_u.rd(mgmt_pkg::OFS_FLAGS, d, ok);
      chk(d, {4'h0, flagsExp});
      flagsExp = 4'h0;
    end
    // clock enable low freezes the synchronised pins
    idle(1);
    ctl = lowPowerRequest;
    ce = 1'b0;
    lowPowerRequest = ~ctl;
    idle(10);
    chk(powerLimit, ctl);
    ce = 1'b1;
    idle(10);
    chk(powerLimit, lowPowerRequest);
    transmitDisable = 1'b0;
    host_u.wr(mgmt_pkg::OFS_CONTROL, 8'h01, ok);
    idle(1);
    // a pulse below the minimum width must be ignored
    moduleResetN = 1'b0;
    idle(50);
    moduleResetN = 1'b1;
    idle(10);
    chk({dataNotReady, transmitOff}, 32'h1);
    moduleResetN = 1'b0;
    idle(120);
    chk({dataNotReady, transmitOff}, 32'h2);
    moduleResetN = 1'b1;
    waitReady();
    chk(attentionOe, 32'h1);
    host_u.rd(mgmt_pkg::OFS_CONTROL, d, ok);
    chk(d, 32'h0);
    stop_test();
  end
endmodule
